// [rtl/ebf_pkg.sv]
// package: register map, field positions and reset values of the extended bus filter config
`default_nettype none
package ebf_pkg;
  localparam logic [7:0]  REG_INDEX_CFG     = 8'h3F;
  localparam logic [7:0]  REG_INDEX_CTRL    = 8'h40;
  localparam logic [9:0]  ADDR_CFG          = {REG_INDEX_CFG, 2'b00};
  localparam logic [9:0]  ADDR_CTRL         = {REG_INDEX_CTRL, 2'b00};
  localparam int          CFG_W             = 16;
  localparam int          POS_OUT_LSB       = 12;
  localparam int          POS_HOLD_PHASE    = 4;
  localparam int          POS_CMP_MATCH     = 2;
  localparam int          POS_CMP_NOMATCH   = 1;
  localparam int          POS_REJECT        = 0;
  localparam int          POS_EXT_BUS       = 0;
  localparam logic [15:0] CFG_WRITE_MASK    = 16'hF017;
  localparam logic [15:0] CFG_RESET_VAL     = 16'h0000;
  localparam logic [1:0]  RESP_OKAY         = 2'b00;
  localparam logic [1:0]  RESP_SLVERR       = 2'b10;
  typedef enum logic [1:0] {
    EBF_RX_IDLE = 2'b00,
    EBF_RX_ADDR = 2'b01,
    EBF_RX_DONE = 2'b11
  } ebf_rx_state_t;
endpackage : ebf_pkg
`default_nettype wire

// [rtl/ebf_config.sv]
// extended bus filter config register with output, hold phase and filter logic
`default_nettype none
// Overview of operation
// (R1) Hardware reset clears the register except the four output level bits.
// (R2) Software reset leaves the register untouched.
// (R3) Software should write the register only while the controller is in software reset.
// (R4) Bits 11..5 and 3 are written as zero and read back with no meaning.
// (R5) As bus master, bits 15..12 set the levels of the four extended user pins.
// (R6) The extended user pins are provided only when extended bus mode is selected.
// (R7) Hold phase 0 changes the hold request on the falling edge, 1 on the rising edge.
// (R8) Compress-on-match alone asserts packet compress on a CAM hit.
// (R9) Compress-on-nomatch alone asserts packet compress on a CAM miss.
// (R10) Software never sets both compress bits at once.
// (R11) With both compress bits clear the packet compress pin floats.
// (R12) Packet compress is never asserted for a broadcast destination.
// (R13) Reject-on-match discards CAM-matching frames, otherwise they are accepted.
// (R14) Reject-on-match inverts only the CAM decision, not broadcast, promiscuous or multicast.
// (R15) With reject and accept-broadcast set, broadcasts pass and other CAM hits drop.
// (R16) Packet compress is driven after address compare and held until the frame ends.
module ebf_config
  import ebf_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        soft_reset,
  input  wire logic        bus_master,
  input  wire logic        hold_req,
  input  wire logic        frame_start,
  input  wire logic        addr_done,
  input  wire logic        frame_end,
  input  wire logic        cam_match,
  input  wire logic        dest_broadcast,
  input  wire logic        dest_multicast,
  input  wire logic        accept_broadcast,
  input  wire logic        promiscuous_physical,
  input  wire logic        accept_all_multicast,
  output logic      [3:0]  ext_user_pins,
  output logic             ext_user_pins_oe,
  output logic             hold_rise,
  output logic             hold_fall,
  output logic             packet_compress_out,
  output logic             packet_compress_oe,
  output logic             frame_accept,
  output logic             frame_accept_valid,
  input  wire logic [9:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [9:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  logic [CFG_W-1:0] cfg_r;
  logic [3:0]       out_lvl_r;
  logic [11:0]      cfg_lo_r;
  logic             wr_cfg_hit;
  logic             wr_ctrl_hit;
  logic             rd_cfg_hit;
  logic             rd_ctrl_hit;
  logic             ext_bus_mode_r;
  logic [9:0]       awaddr_r;
  logic             aw_held_r;
  logic [31:0]      wdata_r;
  logic [3:0]       wstrb_r;
  logic             w_held_r;
  logic             do_write;
  logic [9:0]       wr_addr;
  logic [31:0]      wr_data;
  logic [3:0]       wr_strb;
  logic [15:0]      cfg_nxt;

  assign wr_addr  = aw_held_r ? awaddr_r : s_axi_awaddr;
  assign wr_data  = w_held_r ? wdata_r : s_axi_wdata;
  assign wr_strb  = w_held_r ? wstrb_r : s_axi_wstrb;
  assign do_write = (aw_held_r || (s_axi_awvalid && s_axi_awready))
                 && (w_held_r || (s_axi_wvalid && s_axi_wready));

  // byte-lane merge, reserved bits forced to zero
  function automatic logic [15:0] merge_cfg(input logic [15:0] old_v,
                                            input logic [31:0] d,
                                            input logic [3:0]  s);
    logic [15:0] v;
    v = old_v;
    if (s[0]) begin
      v[7:0] = d[7:0];
    end
    if (s[1]) begin
      v[15:8] = d[15:8];
    end
    merge_cfg = v & CFG_WRITE_MASK;
  endfunction : merge_cfg

  assign cfg_nxt = merge_cfg(cfg_r, wr_data, wr_strb);

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // index match shared by write, read and response logic
  function automatic logic addr_is(input logic [9:0] a,
                                   input logic [7:0] idx);
    addr_is = (a[9:2] == idx);
  endfunction : addr_is

  assign wr_cfg_hit  = addr_is(wr_addr, REG_INDEX_CFG);
  assign wr_ctrl_hit = addr_is(wr_addr, REG_INDEX_CTRL);
  assign rd_cfg_hit  = addr_is(s_axi_araddr, REG_INDEX_CFG);
  assign rd_ctrl_hit = addr_is(s_axi_araddr, REG_INDEX_CTRL);

  // ----------------------------------------
  // write channel
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      awaddr_r      <= 10'h000;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_r && !s_axi_bvalid && !do_write
                    && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held_r && !s_axi_bvalid && !do_write
                    && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready && !do_write) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready && !do_write) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_cfg_hit || wr_ctrl_hit)
                      ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // config storage
  // ----------------------------------------
  // reset-cleared part; soft reset does not touch it
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_lo_r <= CFG_RESET_VAL[11:0];                 // [R1] [R2]
    end else if (do_write && wr_cfg_hit) begin
      cfg_lo_r <= cfg_nxt[11:0];                       // [R4]
    end
  end

  // output level bits are not reset, unknown until written
  always_ff @(posedge clk) begin
    if (!srst && do_write && wr_cfg_hit) begin
      out_lvl_r <= cfg_nxt[15:12];                     // [R1]
    end
  end

  // one view of the whole register for readback and decode
  assign cfg_r = {out_lvl_r, cfg_lo_r};

  // extended bus mode select
  always_ff @(posedge clk) begin
    if (srst) begin
      ext_bus_mode_r <= 1'b0;
    end else if (do_write && wr_ctrl_hit && wr_strb[0]) begin
      ext_bus_mode_r <= wr_data[POS_EXT_BUS];
    end
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        if (rd_cfg_hit) begin
          s_axi_rdata <= {16'h0000, cfg_r};            // [R4]
        end else if (rd_ctrl_hit) begin
          // status: soft reset level, decision, compress pin, mode bit
          s_axi_rdata <= {27'h0, soft_reset, frame_accept, packet_compress_oe,
                          packet_compress_out, ext_bus_mode_r};
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // extended user pins and hold phase
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      ext_user_pins    <= 4'h0;
      ext_user_pins_oe <= 1'b0;
    end else begin
      ext_user_pins    <= cfg_r[POS_OUT_LSB +: 4];     // [R5]
      ext_user_pins_oe <= bus_master && ext_bus_mode_r; // [R5] [R6]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      hold_rise <= 1'b0;
      hold_fall <= 1'b0;
    end else begin
      hold_rise <= cfg_r[POS_HOLD_PHASE] && hold_req;  // [R7]
      hold_fall <= !cfg_r[POS_HOLD_PHASE] && hold_req; // [R7]
    end
  end

  // ----------------------------------------
  // receive filter and packet compress
  // ----------------------------------------
  ebf_rx_state_t rx_state_r;
  logic          compress_hit;
  logic          cam_accept;
  logic          rule_accept;

  assign compress_hit = !dest_broadcast                                      // [R12]
    && ((cfg_r[POS_CMP_MATCH] && !cfg_r[POS_CMP_NOMATCH] && cam_match)       // [R8]
     || (cfg_r[POS_CMP_NOMATCH] && !cfg_r[POS_CMP_MATCH] && !cam_match));    // [R9]
  assign cam_accept  = cam_match ^ cfg_r[POS_REJECT];                        // [R13] [R14]
  // promiscuous covers physical destinations only, never group addresses
  assign rule_accept = (dest_broadcast && accept_broadcast)
                    || (promiscuous_physical && !dest_multicast && !dest_broadcast)
                    || (dest_multicast && !dest_broadcast && accept_all_multicast)
                    || (!dest_broadcast && cam_accept);                       // [R14] [R15]

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_state_r          <= EBF_RX_IDLE;
      packet_compress_out <= 1'b0;
      packet_compress_oe  <= 1'b0;
      frame_accept        <= 1'b0;
      frame_accept_valid  <= 1'b0;
    end else begin
      frame_accept_valid <= 1'b0;
      packet_compress_oe <= cfg_r[POS_CMP_MATCH] || cfg_r[POS_CMP_NOMATCH]; // [R11]
      unique case (rx_state_r)
        EBF_RX_IDLE: begin
          packet_compress_out <= 1'b0;
          if (frame_start) begin
            rx_state_r <= EBF_RX_ADDR;
          end
        end
        EBF_RX_ADDR: begin
          if (frame_end) begin
            rx_state_r <= EBF_RX_IDLE;
          end else if (addr_done) begin
            packet_compress_out <= compress_hit;       // [R16]
            frame_accept        <= rule_accept;        // [R13]
            frame_accept_valid  <= 1'b1;
            rx_state_r          <= EBF_RX_DONE;
          end
        end
        EBF_RX_DONE: begin
          if (frame_end) begin
            packet_compress_out <= 1'b0;               // [R16]
            rx_state_r          <= EBF_RX_IDLE;
          end
        end
        default: begin
          rx_state_r <= EBF_RX_IDLE;
        end
      endcase
    end
  end

endmodule : ebf_config
`default_nettype wire

// [testbench/ebf_config_checker.sv]
// checker: port timing relations of the extended bus filter config block
`default_nettype none
module ebf_config_checker (
  input wire logic clk,
  input wire logic srst,
  input wire logic hold_req,
  input wire logic hold_rise,
  input wire logic hold_fall,
  input wire logic bus_master,
  input wire logic ext_user_pins_oe,
  input wire logic addr_done,
  input wire logic dest_broadcast,
  input wire logic frame_end,
  input wire logic frame_accept_valid,
  input wire logic packet_compress_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  rst_quiet_a: assert property ($past(srst) |-> !frame_accept_valid && !packet_compress_out)
    else $error("outputs busy after reset");
  hold_track_a: assert property (!$past(srst) |-> (hold_rise | hold_fall) == $past(hold_req))
    else $error("hold request not passed on");
  hold_excl_a: assert property (!(hold_rise && hold_fall))
    else $error("hold on both phases");
  ext_oe_a: assert property (!$past(bus_master) && !$past(srst) |-> !ext_user_pins_oe)
    else $error("user pins driven while not bus owner");
  dec_cause_a: assert property (frame_accept_valid |-> $past(addr_done))
    else $error("decision without compare");
  dec_pulse_a: assert property (frame_accept_valid |=> !frame_accept_valid)
    else $error("decision pulse too long");
  bcast_nocomp_a: assert property (frame_accept_valid && $past(dest_broadcast)
    |-> !packet_compress_out) else $error("compress on broadcast");
  comp_hold_a: assert property (packet_compress_out && !frame_end |=> packet_compress_out)
    else $error("compress dropped in frame");
  comp_drop_a: assert property (frame_end |=> !packet_compress_out)
    else $error("compress held after frame");
  cover property (frame_accept_valid && packet_compress_out);
  cover property (hold_rise);
  cover property (frame_accept_valid && dest_broadcast);
endmodule : ebf_config_checker
bind ebf_config ebf_config_checker u_chk (.*);
`default_nettype wire

// [testbench/ebf_rx_src.sv]
// partner: receive frame source with address compare results
`default_nettype none
module ebf_rx_src (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic go,
  input  wire logic m,
  input  wire logic b,
  input  wire logic mc,
  output logic      frame_start,
  output logic      addr_done,
  output logic      frame_end,
  output logic      cam_match,
  output logic      dest_broadcast,
  output logic      dest_multicast
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt_r;
  always_ff @(posedge clk) begin
    if (srst) cnt_r <= 3'h0;
    else if (go || cnt_r != 3'h0) cnt_r <= cnt_r + 3'h1;
  end
  assign frame_start = (cnt_r == 3'h1);
  assign addr_done = (cnt_r == 3'h3);
  assign frame_end = (cnt_r == 3'h6);
  // compare flags are valid only at compare time
  assign {cam_match, dest_broadcast, dest_multicast} = addr_done ? {m, b, mc} : {3{cnt_r[0]}};
endmodule : ebf_rx_src
`default_nettype wire

// [testbench/ebf_config_tb.sv]
// testbench: random config, register bus and frame filter checks
`default_nettype none
module ebf_config_tb
  import ebf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, srst, soft_reset, bus_master, hold_req, go, m, b, mc, ext, exp_c;
  logic accept_broadcast, promiscuous_physical, accept_all_multicast;
  logic frame_start, addr_done, frame_end, cam_match, dest_broadcast, dest_multicast;
  logic ext_user_pins_oe, hold_rise, hold_fall, packet_compress_out, packet_compress_oe;
  logic frame_accept, frame_accept_valid, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [3:0]  ext_user_pins, s_axi_wstrb;
  logic [9:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, rnd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic [15:0] cfg;
  int seed = 22;
  int error_cnt = 0;
  int num_checks = 0;
  ebf_config i_dut (.*);
  ebf_rx_src i_src (.*);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // -------------
  // shared tasks
  // -------------
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [9:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rdr
  // -------------
  // main sequence
  // -------------
  initial begin
    srst = 1'b1;
    {soft_reset, bus_master, hold_req, go, m, b, mc} = 7'h00;
    {accept_broadcast, promiscuous_physical, accept_all_multicast} = 3'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 52'h0;
    s_axi_wstrb = 4'h3;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rdr(ADDR_CFG);
    chk("cfg_reset", {20'h0, rd[11:0]}, 32'h0);
    wr(10'h004, 16'h0001);
    chk("wr_unmapped", {30'h0, rr}, {30'h0, RESP_SLVERR});
    rdr(10'h004);
    chk("rd_unmapped", {rd[29:0], rr}, {30'h0, RESP_SLVERR});
    for (int i = 0; i < 40; i++) begin
      rnd = $random(seed);
      cfg = {rnd[15:12], 7'h00, rnd[4], 1'b0, (rnd[6:5] == 2'b11) ? 2'b01 : rnd[6:5], rnd[0]};
      if (i == 0) cfg = 16'hF011;
      ext = rnd[7];
      soft_reset <= 1'b1;
      wr(ADDR_CFG, cfg);
      chk("wr_resp", {30'h0, rr}, {30'h0, RESP_OKAY});
      wr(ADDR_CTRL, {15'h0000, ext});
      rdr(ADDR_CFG);
      chk("cfg_rb", rd, {16'h0000, cfg});
      soft_reset <= 1'b0;
      bus_master <= rnd[8];
      hold_req <= rnd[9];
      {accept_broadcast, promiscuous_physical, accept_all_multicast} <= rnd[18:16];
      {m, b, mc} <= {rnd[19], rnd[20] | (i == 0), rnd[21] & ~rnd[20]};
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      do @(posedge clk); while (!frame_accept_valid);
      exp_c = !b && (cfg[2] ? m : cfg[1] & !m);
      chk("comp_oe", packet_compress_oe, cfg[2] | cfg[1]);
      chk("comp", packet_compress_out, exp_c);
      chk("accept", frame_accept, b ? accept_broadcast
        : (m ^ cfg[0]) | (mc ? accept_all_multicast : promiscuous_physical));
      chk("pins", {ext_user_pins_oe, ext_user_pins}, {bus_master & ext, cfg[15:12]});
      chk("hold", {hold_rise, hold_fall}, {cfg[4], !cfg[4]} & {2{hold_req}});
      do @(posedge clk); while (!frame_end);
      chk("comp_held", packet_compress_out, exp_c);
      @(posedge clk);
      chk("comp_end", packet_compress_out, 1'b0);
      rdr(ADDR_CFG);
      chk("cfg_soft", rd, {16'h0000, cfg});
    end
    close_out();
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    close_out();
  end
endmodule : ebf_config_tb
`default_nettype wire
